// ===== inc/cdm_pkg.sv
package cdm_pkg;

   // ****************************************************************
   // Register map (word index on the plain register port)
   // ****************************************************************
   localparam logic [1:0] CDM_ADDR_CONTROL = 2'h0;
   localparam logic [1:0] CDM_ADDR_SOURCE  = 2'h1;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CDM_CTL_MODULE_ON  = 7;
   localparam int CDM_CTL_DRIVE_EN   = 6;
   localparam int CDM_CTL_SLEW_LIMIT = 5;
   localparam int CDM_CTL_INVERT     = 4;
   localparam int CDM_CTL_OUT_STATE  = 3;
   localparam int CDM_CTL_SOFT_MOD   = 0;

   // Writable bits of each register; the rest read zero, except control bit 3, which reads the registered mixer output
   localparam logic [7:0] CDM_CTL_WMASK   = 8'hF1;
   localparam logic [7:0] CDM_CTL_RESET   = 8'h20;
   localparam logic [7:0] CDM_SRC_WMASK   = 8'h8F;
   localparam logic [7:0] CDM_SRC_RESET   = 8'h00;
   localparam int         CDM_SRC_RELEASE = 7;

   // ****************************************************************
   // Modulator source encodings
   // ****************************************************************
   localparam logic [3:0] CDM_MS_SOFT  = 4'h0;
   localparam logic [3:0] CDM_MS_PIN   = 4'h1;
   localparam logic [3:0] CDM_MS_CAP   = 4'h2;
   localparam logic [3:0] CDM_MS_CMP1  = 4'h6;
   localparam logic [3:0] CDM_MS_CMP2  = 4'h7;
   localparam logic [3:0] CDM_MS_SDO   = 4'h8;
   localparam logic [3:0] CDM_MS_TX    = 4'hA;

   // Peripheral modulator candidates, all on the core clock
   typedef struct packed {
      logic cap_out;
      logic cmp1_out;
      logic cmp2_out;
      logic sdo_out;
      logic tx_out;
   } cdm_periph_type;

   // Pin-release levels, held while the release bit is set, back to the peripherals' own pin drivers
   typedef struct packed {
      logic cap_release;
      logic cmp1_release;
      logic cmp2_release;
      logic sdo_release;
      logic tx_release;
   } cdm_release_type;

endpackage

// ===== hw/cdm_modulator.sv
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps

// Behaviour
// - Mixer keeps running in sleep; no sleep input gates it.
// - Any reset leaves the modulator disabled.
// - Reset restores registers; slew limit reads one, other bits zero.
// - Software modulator bit matters only when selected as source.
// - Module-off grounds both carriers, modulator from software bit, keeps selections.
// - Drive-enable clear holds output pin low while mixing continues.
// - Output is modulator AND high carrier, or inverted modulator AND low carrier.
// - Invert bit drives inverse of mixed signal to the pin.
module cdm_modulator (
   input  wire logic                     clock,
   input  wire logic                     nrst,
   input  wire logic [1:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_write,
   input  wire logic                     reg_read,
   output logic      [7:0]               reg_rdata,
   input  wire logic                     carrier_hi,
   input  wire logic                     carrier_lo,
   input  wire logic                     mod_pin,
   input  wire cdm_pkg::cdm_periph_type  periph,
   output cdm_pkg::cdm_release_type      release_o,
   output logic                          modulated_out,
   output logic                          slew_limit
);
   import cdm_pkg::*;

   // ****************************************************************
   // Synchronisers for pin inputs
   // ****************************************************************
   logic [2:0] pin_meta_q;
   logic [2:0] pin_meta_d;
   logic [2:0] pin_sync_q;
   logic [2:0] pin_sync_d;

   always_comb begin
      pin_meta_d = {carrier_hi, carrier_lo, mod_pin};
      pin_sync_d = pin_meta_q;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pin_meta_q <= 3'h0;
         pin_sync_q <= 3'h0;
      end else begin
         pin_meta_q <= pin_meta_d;
         pin_sync_q <= pin_sync_d;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0] control_q;
   logic [7:0] control_d;
   logic [7:0] source_q;
   logic [7:0] source_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       mixed_q;
   logic       mixed_d;
   logic       out_q;
   logic       out_d;

   // Masked merge keeps unimplemented and read-only bits at zero
   function automatic logic [7:0] merge(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic [7:0] wmask);
      merge = (old_v & ~wmask) | (new_v & wmask);
   endfunction

   always_comb begin
      control_d = control_q;
      source_d  = source_q;
      if (reg_write) begin
         if (reg_addr == CDM_ADDR_CONTROL) begin
            control_d = merge(control_q, reg_wdata, CDM_CTL_WMASK);
         end else if (reg_addr == CDM_ADDR_SOURCE) begin
            source_d = merge(source_q, reg_wdata, CDM_SRC_WMASK);
         end
      end
   end

   always_comb begin
      rdata_d = 8'h00;
      if (reg_read) begin
         if (reg_addr == CDM_ADDR_CONTROL) begin
            rdata_d = control_q;
            rdata_d[CDM_CTL_OUT_STATE] = mixed_q;
         end else if (reg_addr == CDM_ADDR_SOURCE) begin
            rdata_d = source_q;
         end
      end
   end

   // Reset clears the enable and restores defaults
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         control_q <= CDM_CTL_RESET;
         source_q  <= CDM_SRC_RESET;
         rdata_q   <= 8'h00;
      end else begin
         control_q <= control_d;
         source_q  <= source_d;
         rdata_q   <= rdata_d;
      end
   end

   // ****************************************************************
   // Mixer
   // ****************************************************************
   logic       module_on;
   logic [3:0] mod_src_sel;
   logic       mod_sel;
   logic       car_hi;
   logic       car_lo;
   logic       mod_val;

   always_comb begin
      module_on   = control_q[CDM_CTL_MODULE_ON];
      mod_src_sel = source_q[3:0];
      // Reserved encodings connect nothing, so they read as low
      case (mod_src_sel)
         CDM_MS_SOFT: mod_sel = control_q[CDM_CTL_SOFT_MOD];
         CDM_MS_PIN:  mod_sel = pin_sync_q[0];
         CDM_MS_CAP:  mod_sel = periph.cap_out;
         CDM_MS_CMP1: mod_sel = periph.cmp1_out;
         CDM_MS_CMP2: mod_sel = periph.cmp2_out;
         CDM_MS_SDO:  mod_sel = periph.sdo_out;
         CDM_MS_TX:   mod_sel = periph.tx_out;
         default:     mod_sel = 1'b0;
      endcase
      // Off state grounds carriers to save switching power; selections stay put
      car_hi  = module_on & pin_sync_q[2];
      car_lo  = module_on & pin_sync_q[1];
      mod_val = module_on ? mod_sel : control_q[CDM_CTL_SOFT_MOD];
      // No sleep input exists, so the mixer simply keeps running
      mixed_d = mod_val ? car_hi : car_lo;
      out_d   = control_q[CDM_CTL_DRIVE_EN]
                & (mixed_d ^ control_q[CDM_CTL_INVERT]);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mixed_q <= 1'b0;
         out_q   <= 1'b0;
      end else begin
         mixed_q <= mixed_d;
         out_q   <= out_d;
      end
   end

   // ****************************************************************
   // Pin release toward peripherals
   // ****************************************************************
   logic rel;

   always_comb begin
      rel = source_q[CDM_SRC_RELEASE];
      release_o.cap_release  = rel & (mod_src_sel == CDM_MS_CAP);
      release_o.cmp1_release = rel & (mod_src_sel == CDM_MS_CMP1);
      release_o.cmp2_release = rel & (mod_src_sel == CDM_MS_CMP2);
      release_o.sdo_release  = rel & (mod_src_sel == CDM_MS_SDO);
      release_o.tx_release   = rel & (mod_src_sel == CDM_MS_TX);
   end

   assign reg_rdata     = rdata_q;
   assign modulated_out = out_q;
   assign slew_limit    = control_q[CDM_CTL_SLEW_LIMIT];

endmodule

// ===== test/cdm_mod_properties.sv
`timescale 1ns/1ps
module cdm_mod_properties (
   input wire logic                    clock,
   input wire logic                    nrst,
   input wire logic [1:0]              reg_addr,
   input wire logic [7:0]              reg_wdata,
   input wire logic                    reg_write,
   input wire logic                    reg_read,
   input wire logic [7:0]              reg_rdata,
   input wire logic                    carrier_hi,
   input wire logic                    carrier_lo,
   input wire logic                    mod_pin,
   input wire cdm_pkg::cdm_periph_type  periph,
   input wire cdm_pkg::cdm_release_type release_o,
   input wire logic                    modulated_out,
   input wire logic                    slew_limit
);
   import cdm_pkg::*;
   // ****
   // Shadow of the registers, rebuilt from bus traffic
   // ****
   logic [7:0] ctl_q;
   logic [7:0] src_q;
   logic [3:0] ms;
   logic       sel;
   logic       md;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctl_q <= CDM_CTL_RESET;
         src_q <= CDM_SRC_RESET;
      end else if (reg_write && reg_addr == CDM_ADDR_CONTROL) begin
         ctl_q <= reg_wdata & CDM_CTL_WMASK;
      end else if (reg_write && reg_addr == CDM_ADDR_SOURCE) begin
         src_q <= reg_wdata & CDM_SRC_WMASK;
      end
   end
   assign ms = src_q[3:0];
   // Only the soft and TX sources are modelled, to keep this short
   assign sel = ctl_q[7] && ctl_q[6] && (ms == CDM_MS_SOFT || ms == CDM_MS_TX);
   assign md = (ms == CDM_MS_SOFT) ? ctl_q[0] : periph.tx_out;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_rst; !$past(nrst) |-> slew_limit && !modulated_out; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_slw; reg_write && reg_addr == 2'h0 |=> slew_limit == $past(reg_wdata[5]); endproperty
   a_slw: assert property (p_slw) else $error("slew bit");
   property p_off; !$past(ctl_q[7]) |-> modulated_out == ($past(ctl_q[6]) && $past(ctl_q[4]));
   endproperty
   a_off: assert property (p_off) else $error("module off output");
   property p_drv; !$past(ctl_q[6]) |-> !modulated_out; endproperty
   a_drv: assert property (p_drv) else $error("drive off output");
   property p_mix; $past(sel) |-> modulated_out == ($past(ctl_q[4]) ^
      ($past(md) ? $past(carrier_hi, 3) : $past(carrier_lo, 3))); endproperty
   a_mix: assert property (p_mix) else $error("mixed output");
   property p_rel; release_o == (src_q[7] ? {ms == CDM_MS_CAP, ms == CDM_MS_CMP1,
      ms == CDM_MS_CMP2, ms == CDM_MS_SDO, ms == CDM_MS_TX} : 5'h00); endproperty
   a_rel: assert property (p_rel) else $error("pin release");
   property p_rdc; reg_read && reg_addr == 2'h0 |=> (reg_rdata & 8'hF7) == $past(ctl_q); endproperty
   a_rdc: assert property (p_rdc) else $error("control read");
   property p_rds; reg_read && reg_addr == 2'h1 |=> reg_rdata == $past(src_q); endproperty
   a_rds: assert property (p_rds) else $error("source read");
   c_mix: cover property ($past(sel) && modulated_out);
   c_off: cover property (!$past(ctl_q[7]) && modulated_out);
   c_rel: cover property (|release_o);
endmodule
bind cdm_modulator cdm_mod_properties u_props (.*);

// ===== test/cdm_far_model.sv
`timescale 1ns/1ps
module cdm_far_model (
   input  wire logic             clock,
   input  wire logic [7:0]       lv,
   output logic                  carrier_hi,
   output logic                  carrier_lo,
   output logic                  mod_pin,
   output cdm_pkg::cdm_periph_type periph
);
   import cdm_pkg::*;
   // Sources move only just after an edge, like on-chip peripherals
   always_ff @(posedge clock) {carrier_hi, carrier_lo, mod_pin, periph} <= lv;
endmodule

// ===== test/cdm_modulator_tb.sv
`timescale 1ns/1ps
module cdm_modulator_tb;
   import cdm_pkg::*;
   logic            clock = 1'b0;
   logic            nrst = 1'b0;
   logic [1:0]      reg_addr = 2'h0;
   logic [7:0]      reg_wdata = 8'h00;
   logic            reg_write = 1'b0;
   logic            reg_read = 1'b0;
   logic [7:0]      lv = 8'h00;
   logic [7:0]      reg_rdata;
   logic            carrier_hi, carrier_lo, mod_pin, modulated_out, slew_limit;
   cdm_periph_type  periph;
   cdm_release_type release_o;
   int              failures = 0;
   int              checked = 0;
   always #2.5 clock = ~clock;
   cdm_modulator dut (.*);
   cdm_far_model far (.*);
   // ****
   // Bus and compare helpers
   // ****
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checked++;
      if (e !== g) begin
         failures++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(logic [1:0] a, logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(logic [1:0] a, logic [7:0] e);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
   endtask
   task automatic end_sim();
      if (failures == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_rst();
      nrst <= 1'b0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      #1 chk("out", 8'h00, {7'h00, modulated_out});
      chk("slew", 8'h01, {7'h00, slew_limit});
      rd(CDM_ADDR_CONTROL, 8'h20);
      rd(CDM_ADDR_SOURCE, 8'h00);
   endtask
   task automatic t_regs();
      wr(CDM_ADDR_CONTROL, 8'hFF);
      rd(CDM_ADDR_CONTROL, 8'hF1);
      wr(CDM_ADDR_SOURCE, 8'hFF);
      rd(CDM_ADDR_SOURCE, 8'h8F);
      rd(2'h2, 8'h00);
      wr(CDM_ADDR_CONTROL, 8'h00);
      #1 chk("slew", 8'h00, {7'h00, slew_limit});
   endtask
   task automatic t_mix(logic [7:0] c, logic [7:0] s, logic [7:0] l, logic o, logic [4:0] r);
      @(posedge clock);
      lv <= l;
      wr(CDM_ADDR_SOURCE, s);
      wr(CDM_ADDR_CONTROL, c);
      repeat (4) @(posedge clock);
      #1 chk("out", {7'h00, o}, {7'h00, modulated_out});
      chk("release", {3'h0, r}, {3'h0, release_o});
   endtask
   initial begin
      #100000;
      failures++;
      end_sim();
   end
   initial begin
      t_rst();
      t_regs();
      t_mix(8'hC1, 8'h00, 8'h80, 1'b1, 5'h00);
      rd(CDM_ADDR_CONTROL, 8'hC9);
      t_mix(8'hC0, 8'h00, 8'h40, 1'b1, 5'h00);
      t_mix(8'hC0, 8'h81, 8'hA0, 1'b1, 5'h00);
      t_mix(8'hC0, 8'h82, 8'h90, 1'b1, 5'h10);
      t_mix(8'hC0, 8'h86, 8'h88, 1'b1, 5'h08);
      t_mix(8'hC0, 8'h87, 8'h84, 1'b1, 5'h04);
      t_mix(8'hC0, 8'h88, 8'h82, 1'b1, 5'h02);
      t_mix(8'hC0, 8'h8A, 8'h81, 1'b1, 5'h01);
      t_mix(8'hC1, 8'h0A, 8'h40, 1'b1, 5'h00);
      t_mix(8'hC0, 8'h03, 8'hFF, 1'b1, 5'h00);
      t_mix(8'hD0, 8'h0A, 8'h81, 1'b0, 5'h00);
      t_mix(8'h90, 8'h0A, 8'h81, 1'b0, 5'h00);
      t_mix(8'h51, 8'h0A, 8'hC1, 1'b1, 5'h00);
      rd(CDM_ADDR_SOURCE, 8'h0A);
      t_rst();
      t_mix(8'h41, 8'h0A, 8'hC1, 1'b0, 5'h00);
      end_sim();
   end
endmodule
